// ==== hdl/lin_flag_consts.svh ====
`ifndef LIN_FLAG_CONSTS_SVH
`define LIN_FLAG_CONSTS_SVH

// Frame layout
`define FRAME_BITS 16
`define CMD_MSB 15
`define CMD_LSB 14
`define ADDR_MSB 13
`define ADDR_LSB 9
`define RW_BIT 8
`define GROUP_BIT 7

// Command codes in bits 15:14
`define CMD_FLAG_READ 2'b11
`define CMD_STATUS_READ 2'b00
`define CMD_WRITE 2'b01

// Addresses
`define ADDR_REGULATOR_FLAGS 5'h0f
`define ADDR_CAN_FLAGS 5'h10
`define ADDR_LIN_CONTROL 5'h13

// Control register fields and reset
`define CTRL_RESET 8'h00
`define CTRL_MODE_MSB 7
`define CTRL_MODE_LSB 6
`define CTRL_SLEW_MSB 5
`define CTRL_SLEW_LSB 4
`define CTRL_TERM_BIT 2
`define CTRL_EXT_BIT 0
`define MODE_OFF 2'b00
`define MODE_WAKE 2'b10
`define MODE_TRX 2'b11

// Flag group indices and positions
`define GRP_REGL_LO 0
`define GRP_REGL_HI 1
`define GRP_CAN_LO 2
`define GRP_CAN_HI 3
`define AUX_LOW_BIT 7
`define FLAGS_RESET 8'h00

// Auxiliary rail filter time
`define CLK_MHZ 200
`define AUX_FILT_US 100
`define AUX_FILT_CYC (`AUX_FILT_US * `CLK_MHZ)

`endif

// ==== hdl/lin_flag_pkg.sv ====
package lin_flag_pkg;

  typedef enum logic [0:0] {
    SPI_IDLE = 1'b0,
    SPI_SHIFT = 1'b1
  } spi_state_e;

  typedef logic [7:0] byte_t;

endpackage

// ==== hdl/lin_ctrl_flags.sv ====
`include "lin_flag_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module lin_ctrl_flags #(
  parameter int AUX_FILT_CYC = `AUX_FILT_CYC
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_B,
  // Serial port
  input wire logic CSB,
  input wire logic SCLK,
  input wire logic MOSI,
  output logic MISO,
  output logic MISO_OE,
  // LIN control
  input wire logic TXD_L,
  input wire logic SUP2_LOW,
  input wire logic TRX_REG_ON,
  output logic LIN_TRX_EN,
  output logic LIN_WAKE_EN,
  output logic LIN_TERM_ON,
  output logic [1:0] LIN_SLEW,
  output logic LIN_RECESSIVE,
  // Fault levels
  input wire logic AUX_BELOW,
  input wire logic [7:0] REGL_FAULT_LO,
  input wire logic [7:0] REGL_FAULT_HI,
  input wire logic [7:0] CAN_FAULT_LO,
  input wire logic [7:0] CAN_FAULT_HI,
  // Latched flags
  output logic [7:0] REGL_FLAGS_LO,
  output logic [7:0] REGL_FLAGS_HI,
  output logic [7:0] CAN_FLAGS_LO,
  output logic [7:0] CAN_FLAGS_HI
);

  localparam int CW = $clog2(AUX_FILT_CYC + 1);

  // Serial shifter
  lin_flag_pkg::spi_state_e state_ff, nxt_state;
  logic sclk_ff, nxt_sclk;
  logic csb_ff, nxt_csb;
  logic [4:0] cnt_ff, nxt_cnt;
  logic [15:0] rx_ff, nxt_rx;
  logic [15:0] tx_ff, nxt_tx;
  logic [7:0] resp_ff, nxt_resp;
  logic miso_ff, nxt_miso;
  logic oe_ff, nxt_oe;
  // Control and flags
  logic [7:0] ctrl_ff, nxt_ctrl;
  logic rec_ff, nxt_rec;
  logic trx_ff, nxt_trx;
  logic wake_ff, nxt_wake;
  logic [CW-1:0] aux_cnt_ff, nxt_aux_cnt;
  logic [7:0] flag_ff [0:3];
  logic [7:0] nxt_flag [0:3];
  logic [7:0] present [0:3];
  logic [7:0] event_in [0:3];
  logic [3:0] clr;
  logic aux_set;
  logic frame_end;
  logic [4:0] frame_addr;
  logic frame_rd;

  function automatic logic [3:0] group_onehot(input logic [4:0] addr, input logic sel);
    group_onehot = 4'h0;
    if (addr == `ADDR_REGULATOR_FLAGS) begin
      if (sel) begin
        group_onehot = 4'h2;
      end else begin
        group_onehot = 4'h1;
      end
    end else if (addr == `ADDR_CAN_FLAGS) begin
      if (sel) begin
        group_onehot = 4'h8;
      end else begin
        group_onehot = 4'h4;
      end
    end
  endfunction

  // Command field match
  function automatic logic is_cmd(input logic [15:0] frame, input logic [1:0] code);
    is_cmd = (frame[`CMD_MSB:`CMD_LSB] == code);
  endfunction

  // Control write with the transmit-receive guard
  function automatic logic [7:0] ctrl_accept(input logic [7:0] wr, input logic [7:0] cur, input logic txd_high);
    ctrl_accept = wr;
    if (wr[`CTRL_MODE_MSB:`CTRL_MODE_LSB] == `MODE_TRX && !txd_high) begin
      ctrl_accept[`CTRL_MODE_MSB:`CTRL_MODE_LSB] = cur[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
    end
  endfunction

  // Aux rail filter: set only after a full low interval
  assign aux_set = AUX_BELOW && (aux_cnt_ff == CW'(AUX_FILT_CYC));

  always_comb begin
    present[`GRP_REGL_LO] = {AUX_BELOW, REGL_FAULT_LO[6:0]};
    present[`GRP_REGL_HI] = {3'h0, REGL_FAULT_HI[4], 1'b0, REGL_FAULT_HI[2:0]};
    present[`GRP_CAN_LO] = {CAN_FAULT_LO[7], 1'b0, CAN_FAULT_LO[5:0]};
    present[`GRP_CAN_HI] = CAN_FAULT_HI;
    event_in[`GRP_REGL_LO] = {aux_set, REGL_FAULT_LO[6:0]};
    event_in[`GRP_REGL_HI] = present[`GRP_REGL_HI];
    event_in[`GRP_CAN_LO] = present[`GRP_CAN_LO];
    event_in[`GRP_CAN_HI] = present[`GRP_CAN_HI];
  end

  // Frame decode shared by the response and control groups
  assign frame_end = (state_ff == lin_flag_pkg::SPI_SHIFT) && CSB && (cnt_ff == 5'(`FRAME_BITS));
  assign frame_addr = rx_ff[`ADDR_MSB:`ADDR_LSB];
  assign frame_rd = rx_ff[`RW_BIT];

  // Serial shifter
  always_comb begin
    nxt_state = state_ff;
    nxt_sclk = SCLK;
    nxt_csb = CSB;
    nxt_cnt = cnt_ff;
    nxt_rx = rx_ff;
    nxt_tx = tx_ff;
    nxt_miso = miso_ff;
    nxt_oe = ~CSB;
    case (state_ff)
      lin_flag_pkg::SPI_IDLE: begin
        if (csb_ff && !CSB) begin
          nxt_state = lin_flag_pkg::SPI_SHIFT;
          nxt_cnt = 5'h00;
          nxt_tx = {4'h0, |flag_ff[3], |flag_ff[2], |flag_ff[1], |flag_ff[0], resp_ff} << 1;
          nxt_miso = 1'b0;
        end
      end
      lin_flag_pkg::SPI_SHIFT: begin
        if (CSB) begin
          nxt_state = lin_flag_pkg::SPI_IDLE;
        end else if (!sclk_ff && SCLK) begin
          nxt_rx = {rx_ff[14:0], MOSI};
          if (cnt_ff != 5'(`FRAME_BITS)) begin
            nxt_cnt = cnt_ff + 5'h01;
          end
        end else if (sclk_ff && !SCLK) begin
          nxt_miso = tx_ff[15];
          nxt_tx = {tx_ff[14:0], 1'b0};
        end
      end
      default: nxt_state = lin_flag_pkg::SPI_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      state_ff <= lin_flag_pkg::SPI_IDLE;
      sclk_ff <= 1'b0;
      csb_ff <= 1'b1;
      cnt_ff <= 5'h00;
      rx_ff <= 16'h0000;
      tx_ff <= 16'h0000;
      miso_ff <= 1'b0;
      oe_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      sclk_ff <= nxt_sclk;
      csb_ff <= nxt_csb;
      cnt_ff <= nxt_cnt;
      rx_ff <= nxt_rx;
      tx_ff <= nxt_tx;
      miso_ff <= nxt_miso;
      oe_ff <= nxt_oe;
    end
  end

  // Read response and group clear
  always_comb begin
    nxt_resp = resp_ff;
    clr = 4'h0;
    if (frame_end) begin
      nxt_resp = 8'h00;
      // Flag read, bit 8 taken as read marker without parity
      if (is_cmd(rx_ff, `CMD_FLAG_READ) && frame_rd) begin
        clr = group_onehot(frame_addr, rx_ff[`GROUP_BIT]);
        for (int g = 0; g < 4; g++) begin
          if (clr[g]) begin
            nxt_resp = flag_ff[g];
          end
        end
      end else if (is_cmd(rx_ff, `CMD_STATUS_READ) && frame_rd && frame_addr == `ADDR_LIN_CONTROL) begin
        nxt_resp = {trx_ff, wake_ff, 6'h00};
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      resp_ff <= 8'h00;
    end else begin
      resp_ff <= nxt_resp;
    end
  end

  // Control register and LIN mode outputs
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (frame_end && is_cmd(rx_ff, `CMD_WRITE) && frame_addr == `ADDR_LIN_CONTROL) begin
      nxt_ctrl = ctrl_accept(rx_ff[7:0], ctrl_ff, TXD_L);
    end
    nxt_trx = (nxt_ctrl[`CTRL_MODE_MSB:`CTRL_MODE_LSB] == `MODE_TRX);
    nxt_wake = nxt_ctrl[`CTRL_MODE_MSB];
    nxt_rec = (SUP2_LOW && !ctrl_ff[`CTRL_EXT_BIT]) || !TRX_REG_ON || !trx_ff;
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      ctrl_ff <= `CTRL_RESET;
      rec_ff <= 1'b1;
      trx_ff <= 1'b0;
      wake_ff <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      rec_ff <= nxt_rec;
      trx_ff <= nxt_trx;
      wake_ff <= nxt_wake;
    end
  end

  // Aux rail low-time counter, saturates at the filter length
  always_comb begin
    nxt_aux_cnt = aux_cnt_ff;
    if (!AUX_BELOW) begin
      nxt_aux_cnt = '0;
    end else if (aux_cnt_ff != CW'(AUX_FILT_CYC)) begin
      nxt_aux_cnt = aux_cnt_ff + CW'(1);
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      aux_cnt_ff <= '0;
    end else begin
      aux_cnt_ff <= nxt_aux_cnt;
    end
  end

  // Latched flags: event sets, read clears only when fault gone, set wins
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_flag
      always_comb begin
        nxt_flag[gi] = flag_ff[gi];
        if (clr[gi]) begin
          nxt_flag[gi] = flag_ff[gi] & present[gi];
        end
        nxt_flag[gi] = nxt_flag[gi] | event_in[gi];
      end
      always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
          flag_ff[gi] <= `FLAGS_RESET;
        end else begin
          flag_ff[gi] <= nxt_flag[gi];
        end
      end
    end
  endgenerate

  // Serial outputs
  assign MISO = miso_ff;
  assign MISO_OE = oe_ff;

  // LIN control outputs
  assign LIN_TRX_EN = trx_ff;
  assign LIN_WAKE_EN = wake_ff;
  assign LIN_TERM_ON = ctrl_ff[`CTRL_TERM_BIT];
  assign LIN_SLEW = ctrl_ff[`CTRL_SLEW_MSB:`CTRL_SLEW_LSB];
  assign LIN_RECESSIVE = rec_ff;

  // Latched flag outputs
  assign REGL_FLAGS_LO = flag_ff[`GRP_REGL_LO];
  assign REGL_FLAGS_HI = flag_ff[`GRP_REGL_HI];
  assign CAN_FLAGS_LO = flag_ff[`GRP_CAN_LO];
  assign CAN_FLAGS_HI = flag_ff[`GRP_CAN_HI];

endmodule

`default_nettype wire

// ==== sim/lin_host.sv ====
`timescale 1ns/10ps
`default_nettype none
module lin_host (
  // Serial bus, host side
  input wire logic clk,
  input wire logic miso,
  output logic csb,
  output logic sclk,
  output logic mosi
);
  initial begin
    csb = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    csb = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi = w[i];
      cyc(4);
      r[i] = miso;
      sclk = 1'b1;
      cyc(3);
      sclk = 1'b0;
    end
    cyc(3);
    csb = 1'b1;
    // Released line shows no stale bit
    mosi = ~mosi;
    cyc(6);
  endtask
endmodule
`default_nettype wire

// ==== sim/lin_ctrl_flags_chk.sv ====
`timescale 1ns/10ps
`default_nettype none
module lin_ctrl_flags_chk #(
  parameter int AUX_FILT_CYC = 20
) (
  // Block inputs
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic CSB,
  input wire logic TXD_L,
  input wire logic SUP2_LOW,
  input wire logic TRX_REG_ON,
  input wire logic AUX_BELOW,
  input wire logic [7:0] REGL_FAULT_LO,
  // Block outputs
  input wire logic MISO_OE,
  input wire logic LIN_TRX_EN,
  input wire logic LIN_TERM_ON,
  input wire logic [1:0] LIN_SLEW,
  input wire logic LIN_RECESSIVE,
  input wire logic [7:0] REGL_FLAGS_LO,
  input wire logic [7:0] REGL_FLAGS_HI,
  input wire logic [7:0] CAN_FLAGS_LO,
  input wire logic [7:0] CAN_FLAGS_HI
);
  logic [2:0] hi_ff;
  logic [15:0] aux_ff;
  wire logic [31:0] fl = {REGL_FLAGS_LO, REGL_FLAGS_HI, CAN_FLAGS_LO, CAN_FLAGS_HI};
  // Run lengths of idle select and low aux rail
  always_ff @(posedge CLK_SYS) begin
    hi_ff <= (!RST_B || !CSB) ? 3'h0 : hi_ff + {2'h0, hi_ff != 3'h7};
    aux_ff <= (!RST_B || !AUX_BELOW) ? 16'h0 : aux_ff + {15'h0, aux_ff != 16'hffff};
  end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);
  property p_rst; $rose(RST_B) |-> LIN_SLEW == 2'h0 && !LIN_TRX_EN && !LIN_TERM_ON; endproperty
  a_rst: assert property (p_rst) else $error("control not cleared");
  property p_txd; $rose(LIN_TRX_EN) |-> $past(TXD_L); endproperty
  a_txd: assert property (p_txd) else $error("trx taken with txd low");
  property p_off; (!LIN_TRX_EN) [*2] |-> LIN_RECESSIVE; endproperty
  a_off: assert property (p_off) else $error("bus driven while off");
  property p_reg; (!TRX_REG_ON) [*2] |-> LIN_RECESSIVE; endproperty
  a_reg: assert property (p_reg) else $error("bus driven, regulator off");
  property p_run; (LIN_TRX_EN && TRX_REG_ON && !SUP2_LOW) [*2] |-> !LIN_RECESSIVE; endproperty
  a_run: assert property (p_run) else $error("bus held recessive");
  property p_hold; hi_ff >= 3'h4 |-> ($past(fl) & ~fl) == 32'h0; endproperty
  a_hold: assert property (p_hold) else $error("flag cleared without read");
  property p_set; $past(RST_B) |-> ($past(REGL_FAULT_LO[6:0]) & ~REGL_FLAGS_LO[6:0]) == 7'h0; endproperty
  a_set: assert property (p_set) else $error("flag not set");
  property p_aux; $rose(REGL_FLAGS_LO[7]) |-> aux_ff >= AUX_FILT_CYC; endproperty
  a_aux: assert property (p_aux) else $error("aux flag too early");
  property p_keep; hi_ff >= 3'h4 |-> $stable({LIN_TRX_EN, LIN_TERM_ON, LIN_SLEW}); endproperty
  a_keep: assert property (p_keep) else $error("control changed");
  property p_oe; MISO_OE == !$past(CSB); endproperty
  a_oe: assert property (p_oe) else $error("output enable not following select");
  c_clr: cover property ($fell(REGL_FLAGS_LO[1]));
  c_trx: cover property ($rose(LIN_TRX_EN));
  c_aux: cover property ($rose(REGL_FLAGS_LO[7]));
endmodule
bind lin_ctrl_flags lin_ctrl_flags_chk #(.AUX_FILT_CYC(AUX_FILT_CYC)) chk (.CLK_SYS, .RST_B, .CSB, .TXD_L,
  .SUP2_LOW, .TRX_REG_ON, .AUX_BELOW, .REGL_FAULT_LO, .MISO_OE, .LIN_TRX_EN, .LIN_TERM_ON, .LIN_SLEW, .LIN_RECESSIVE,
  .REGL_FLAGS_LO, .REGL_FLAGS_HI, .CAN_FLAGS_LO, .CAN_FLAGS_HI);
`default_nettype wire

// ==== sim/lin_ctrl_flags_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module lin_ctrl_flags_tb;
  logic CLK_SYS, RST_B, TXD_L, SUP2_LOW, TRX_REG_ON, AUX_BELOW;
  wire logic CSB, SCLK, MOSI, MISO, MISO_OE, LIN_TRX_EN, LIN_WAKE_EN, LIN_TERM_ON, LIN_RECESSIVE;
  wire logic [1:0] LIN_SLEW;
  wire logic [7:0] fl [4];
  logic [7:0] flt [4];
  logic [7:0] e [4];
  logic [7:0] um [4] = '{8'h7f, 8'h17, 8'hbf, 8'hff};
  logic [7:0] d, sn;
  logic [15:0] r;
  int seed = 32'h5b70757c;
  int fails = 0;
  int n_compared = 0;
  wire logic [7:0] st = {LIN_TRX_EN, LIN_WAKE_EN, LIN_SLEW, 2'h0, LIN_TERM_ON, LIN_RECESSIVE};
  initial begin
    CLK_SYS = 1'b0;
    forever #2.5 CLK_SYS = ~CLK_SYS;
  end
  lin_host h (.clk(CLK_SYS), .miso(MISO), .csb(CSB), .sclk(SCLK), .mosi(MOSI));
  lin_ctrl_flags #(.AUX_FILT_CYC(20)) dut (.CLK_SYS, .RST_B, .CSB, .SCLK, .MOSI, .MISO, .MISO_OE, .TXD_L,
    .SUP2_LOW, .TRX_REG_ON, .LIN_TRX_EN, .LIN_WAKE_EN, .LIN_TERM_ON, .LIN_SLEW, .LIN_RECESSIVE, .AUX_BELOW,
    .REGL_FAULT_LO(flt[0]), .REGL_FAULT_HI(flt[1]), .CAN_FAULT_LO(flt[2]), .CAN_FAULT_HI(flt[3]),
    .REGL_FLAGS_LO(fl[0]), .REGL_FLAGS_HI(fl[1]), .CAN_FLAGS_LO(fl[2]), .CAN_FLAGS_HI(fl[3]));
  // Expected outputs after a control write, supplies healthy
  function automatic logic [7:0] ex(input logic [7:0] v);
    return {v[7:6] == 2'h3, v[7], v[5:4], 2'h0, v[2], v[7:6] != 2'h3};
  endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] x);
    n_compared++;
    if (g !== x) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic conclude;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #100000;
    fails++;
    conclude();
  end
  initial begin
    RST_B = 1'b0;
    TXD_L = 1'b1;
    SUP2_LOW = 1'b0;
    TRX_REG_ON = 1'b1;
    AUX_BELOW = 1'b0;
    flt = '{default: 8'h00};
    h.cyc(3);
    RST_B = 1'b1;
    h.cyc(2);
    chk(st, 8'h01);
    chk({7'h00, MISO_OE}, 8'h00);
    $display("reset test done");
    for (int k = 0; k < 8; k++) begin
      d = 8'($random(seed)) & 8'hf5;
      d[7:6] = 2'(k);
      h.xfer({8'h67, d}, r);
      chk(st, ex(d));
    end
    SUP2_LOW = 1'b1;
    h.xfer(16'h67c0, r);
    chk(st, 8'hc1);
    h.xfer(16'h67c1, r);
    chk(st, 8'hc0);
    TRX_REG_ON = 1'b0;
    h.cyc(3);
    chk(st, 8'hc1);
    TRX_REG_ON = 1'b1;
    SUP2_LOW = 1'b0;
    h.xfer(16'h6700, r);
    TXD_L = 1'b0;
    h.xfer(16'h67c4, r);
    chk(st, 8'h03);
    TXD_L = 1'b1;
    $display("control test done");
    for (int g = 0; g < 4; g++) begin
      flt[g] = (8'($random(seed)) & um[g]) | 8'h03;
      e[g] = flt[g];
    end
    h.cyc(2);
    // Bit 0 faults persist through the reads
    for (int g = 0; g < 4; g++)
      flt[g] = 8'h01;
    for (int g = 0; g < 4; g++) begin
      h.xfer({2'h3, 5'h0f + 5'(g >> 1), 1'b1, g[0], 7'h00}, r);
      sn = e[g];
      e[g] = 8'h01;
      for (int k = 0; k < 4; k++)
        chk(fl[k], e[k]);
      h.xfer(16'h2780, r);
      chk(r[7:0], sn);
    end
    $display("flag test done");
    AUX_BELOW = 1'b1;
    h.cyc(15);
    chk(fl[0] & 8'h80, 8'h00);
    h.cyc(15);
    h.xfer(16'hdf00, r);
    chk(fl[0] & 8'h80, 8'h80);
    AUX_BELOW = 1'b0;
    h.xfer(16'hdf00, r);
    chk(fl[0] & 8'h80, 8'h00);
    $display("aux test done");
    conclude();
  end
endmodule
`default_nettype wire
